// ==== common/sarcs_pkg.sv ====
// Package for the SAR conversion sequencer: constants, modes and carriers
package sarcs_pkg;
    // Core and result widths
    localparam int RAW_W           = 16;
    localparam int RES_W           = 19;
    localparam int CH_W            = 4;
    localparam int CMD_W           = 5;
    localparam int OSR_W           = 2;
    localparam int FIFO_DEPTH      = 32;
    // Clock and timing
    localparam int CLK_MHZ         = 40;
    localparam int CONV_TIME_NS    = 400;
    localparam int CONV_CYCLES     = 16;
    localparam int ACQ_TIME_NS     = 250;
    localparam int ACQ_CYCLES      = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int HIZ_DELAY_NS    = 100;
    localparam int HIZ_CYCLES      = (HIZ_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W           = 5;
    // Oversampling ratio codes: 1, 4, 16, 64
    localparam logic [1:0] OSR_1   = 2'h0;
    localparam logic [1:0] OSR_4   = 2'h1;
    localparam logic [1:0] OSR_16  = 2'h2;
    localparam logic [1:0] OSR_64  = 2'h3;
    // Reset values
    localparam logic [RAW_W-1:0] GAIN_UNITY  = 16'h8000;
    localparam logic [RES_W-1:0] RES_RESET   = 19'h00000;

    // Channel sequencing modes
    typedef enum logic [1:0] {
        SARCS_SEQ_TWO_CYCLE,
        SARCS_SEQ_SINGLE_CYCLE,
        SARCS_SEQ_STANDARD,
        SARCS_SEQ_ADVANCED
    } sarcs_seq_type;

    // Per-channel configuration
    typedef struct packed {
        logic [1:0]        oversample_ratio;
        logic              bipolar;
        logic [RAW_W-1:0]  offset;
        logic [RAW_W-1:0]  gain;
    } sarcs_chcfg_type;

    // Result word pushed into the output buffer
    typedef struct packed {
        logic [CH_W-1:0]   channel;
        logic [1:0]        oversample_ratio;
        logic [RES_W-1:0]  code;
    } sarcs_result_type;

    localparam int RESULT_W = CH_W + 2 + RES_W;
endpackage

// ==== src/sarcs_top.sv ====
// SAR conversion sequencer with result formatting and output FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Result FIFO
module sarcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg, wr_ptr_next;
    logic [AW:0]      rd_ptr_reg, rd_ptr_next;
    logic             full, empty, do_wr, do_rd;

    // Pointer arithmetic and flags
    always_comb begin
        full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
        empty       = (wr_ptr_reg == rd_ptr_reg);
        do_wr       = wr_valid_in && !full;
        do_rd       = rd_ready_in && !empty;
        wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    end

    // Pointer registers
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= wr_data_in;
        end
    end

    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem[rd_ptr_reg[AW-1:0]];
endmodule

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [R1] Mux selection changes at most once per conversion
// [R2] Configuration mode holds core in acquisition
// [R3] Rising convert_start starts conversion in conversion mode
// [R4] Sampling switches open first, acquisition ends
// [R5] Sixteen MSB-first binary weighted trials, decisions recorded
// [R6] Conversion ends after all trials, code ready
// [R7] One 16-bit raw code per conversion
// [R8] Average ratio consecutive codes when ratio above one
// [R9] Busy high during conversion phase when enabled
// [R10] Internal logic schedules next acquisition start
// [R11] Single-cycle mode waits for channel command
// [R12] High-impedance mode delays input switch closing
// [R13] Core runs on internal clock, no serial clock
// [R14] Average, then offset, then gain, then readout
// [R15] Result width 16 to 19 bits by ratio
// [R16] Unipolar straight binary, pseudobipolar twos complement
// [R17] Per-channel offset and gain correction applied
// [R18] Ratio one codes span 0x8000 midscale
// [R19] Ratio four codes 17 bits, midscale 0x10000
// [R20] Ratio sixteen codes 18 bits, midscale 0x20000
// [R21] Ratio sixty-four codes 19 bits, midscale 0x40000
// [R22] Sum codes, shift by half log2 ratio
// [R23] Accumulator clears per result or channel change
module sarcs_top
    import sarcs_pkg::*;
(
    // Clock and reset
    input  wire logic                REF_CLK_IN,
    input  wire logic                RST_B_IN,
    // Host control pins
    input  wire logic                CONVERT_START_IN,
    input  wire logic                CONV_MODE_IN,
    input  wire logic                BUSY_EN_IN,
    input  wire logic                HIZ_EN_IN,
    input  wire sarcs_seq_type       SEQ_MODE_IN,
    // Channel command and sequencer channel
    input  wire logic                CMD_VALID_IN,
    input  wire logic [CMD_W-1:0]    CMD_CHANNEL_IN,
    input  wire logic [CH_W-1:0]     SEQ_CHANNEL_IN,
    input  wire sarcs_chcfg_type     CH_CFG_IN,
    // Comparator decision from the analog core
    input  wire logic                COMPARATOR_IN,
    // Core switch controls
    output logic                     ARRAY_GROUND_SWITCH_POS_OUT,
    output logic                     ARRAY_GROUND_SWITCH_NEG_OUT,
    output logic                     MUX_SWITCH_POS_OUT,
    output logic                     MUX_SWITCH_NEG_OUT,
    output logic [RAW_W-1:0]         DAC_TRIAL_OUT,
    output logic [CH_W-1:0]          MUX_CHANNEL_OUT,
    output logic                     BUSY_OUT,
    // Result stream
    output sarcs_result_type         RESULT_OUT,
    output logic                     RESULT_VALID_OUT,
    input  wire logic                RESULT_READY_IN
);
    typedef enum logic [1:0] {ST_WAIT_CMD, ST_ACQ, ST_CONV, ST_POST} sarcs_state_type;

    // Synchroniser for the convert-start pin only
    logic [1:0] cnv_sync_reg;
    logic       cnv_last_reg;
    logic       cnv_rise;

    // Sequencer state
    sarcs_state_type   state_reg, state_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic [RAW_W-1:0]  sar_reg, sar_next;
    logic [RAW_W-1:0]  trial_reg, trial_next;
    logic [RAW_W-1:0]  dac_reg, dac_next;
    logic [CH_W-1:0]   ch_reg, ch_next;
    logic [CH_W-1:0]   acc_ch_reg, acc_ch_next;
    logic              gnd_sw_reg, gnd_sw_next;
    logic              mux_sw_reg, mux_sw_next;
    logic              busy_reg, busy_next;
    logic              raw_vld_reg, raw_vld_next;
    logic [RAW_W-1:0]  raw_reg, raw_next;
    logic [RAW_W+5:0]  acc_reg, acc_next;
    logic [6:0]        nsamp_reg, nsamp_next;
    logic              avg_vld_reg, avg_vld_next;
    logic [RES_W-1:0]  avg_reg, avg_next;
    sarcs_chcfg_type   cfg_reg, cfg_next;
    sarcs_result_type  res_reg, res_next;
    logic              res_vld_reg, res_vld_next;
    logic              fifo_ready;

    // Helpers for result correction
    logic [6:0]        ratio;
    logic [1:0]        shift;
    logic [RAW_W+5:0]  acc_sum;
    logic signed [RES_W+1:0]  offs_val;
    logic signed [RES_W+RAW_W+2:0] prod;
    logic [RES_W-1:0]  topbit;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser and edge detect on convert start
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            cnv_sync_reg  <= 2'h0;
            cnv_last_reg  <= 1'b0;
        end else begin
            cnv_sync_reg  <= {cnv_sync_reg[0], CONVERT_START_IN};
            cnv_last_reg  <= cnv_sync_reg[1];
        end
    end
    assign cnv_rise = cnv_sync_reg[1] && !cnv_last_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer next state, timed by the block clock only [R13]
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        sar_next     = sar_reg;
        trial_next   = trial_reg;
        ch_next      = ch_reg;
        gnd_sw_next  = gnd_sw_reg;
        mux_sw_next  = mux_sw_reg;
        busy_next    = busy_reg;
        raw_vld_next = 1'b0;
        raw_next     = raw_reg;
        case (state_reg)
            ST_WAIT_CMD: begin
                // Switches stay open until the channel command arrives [R11]
                if (CMD_VALID_IN) begin
                    ch_next     = CMD_CHANNEL_IN[CH_W-1:0]; // [R1]
                    state_next  = ST_ACQ;
                    gnd_sw_next = 1'b1;
                    mux_sw_next = !HIZ_EN_IN; // [R12]
                    cnt_next    = '0;
                end
            end
            ST_ACQ: begin
                if (cnt_reg != CNT_W'(HIZ_CYCLES)) begin
                    cnt_next = cnt_reg + 1'b1;
                end
                if (cnt_reg == CNT_W'(HIZ_CYCLES - 1)) begin
                    mux_sw_next = 1'b1; // [R12]
                end
                // Only conversion mode lets a rising edge start [R2] [R3]
                if (cnv_rise && CONV_MODE_IN) begin
                    state_next  = ST_CONV; // [R4]
                    gnd_sw_next = 1'b0; // [R4]
                    mux_sw_next = 1'b0; // [R4]
                    busy_next   = BUSY_EN_IN; // [R9]
                    sar_next    = '0;
                    trial_next  = GAIN_UNITY; // MSB weight first [R5]
                    cnt_next    = '0;
                end
            end
            ST_CONV: begin
                // Comparator is latched on the core clock, so it is read directly [R5]
                if (COMPARATOR_IN) begin
                    sar_next = sar_reg | trial_reg;
                end
                trial_next = trial_reg >> 1;
                cnt_next   = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
                    raw_next     = COMPARATOR_IN ? (sar_reg | trial_reg) : sar_reg;
                    raw_vld_next = 1'b1; // [R6] [R7]
                    state_next   = ST_POST;
                end
            end
            ST_POST: begin
                busy_next = 1'b0; // [R9]
                // Next acquisition scheduled internally or by command [R10] [R11]
                if (SEQ_MODE_IN == SARCS_SEQ_SINGLE_CYCLE) begin
                    state_next = ST_WAIT_CMD;
                end else begin
                    ch_next     = SEQ_CHANNEL_IN; // [R1]
                    state_next  = ST_ACQ;
                    gnd_sw_next = 1'b1;
                    mux_sw_next = !HIZ_EN_IN; // [R12]
                    cnt_next    = '0;
                end
            end
            default: state_next = ST_ACQ;
        endcase
        dac_next = sar_next | trial_next; // Code under trial, held in a register
    end

    // Sequencer registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            state_reg   <= ST_ACQ;
            cnt_reg     <= '0;
            sar_reg     <= '0;
            trial_reg   <= '0;
            dac_reg     <= '0;
            ch_reg      <= '0;
            gnd_sw_reg  <= 1'b1;
            mux_sw_reg  <= 1'b1;
            busy_reg    <= 1'b0;
            raw_vld_reg <= 1'b0;
            raw_reg     <= '0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            sar_reg     <= sar_next;
            trial_reg   <= trial_next;
            dac_reg     <= dac_next;
            ch_reg      <= ch_next;
            gnd_sw_reg  <= gnd_sw_next;
            mux_sw_reg  <= mux_sw_next;
            busy_reg    <= busy_next;
            raw_vld_reg <= raw_vld_next;
            raw_reg     <= raw_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Averaging and correction next values [R14]
    always_comb begin
        ratio        = 7'h01 << {cfg_reg.oversample_ratio, 1'b0};
        shift        = cfg_reg.oversample_ratio;
        acc_ch_next  = acc_ch_reg;
        cfg_next     = cfg_reg;
        acc_next     = acc_reg;
        nsamp_next   = nsamp_reg;
        avg_vld_next = 1'b0;
        avg_next     = avg_reg;
        acc_sum      = acc_reg + {6'h00, raw_reg};
        if (raw_vld_reg) begin
            // Channel change restarts the average [R23]
            if (ch_reg != acc_ch_reg || nsamp_reg == 7'h00) begin
                acc_ch_next = ch_reg;
                cfg_next    = CH_CFG_IN;
                acc_sum     = {6'h00, raw_reg};
                ratio       = 7'h01 << {CH_CFG_IN.oversample_ratio, 1'b0};
                shift       = CH_CFG_IN.oversample_ratio;
                nsamp_next  = 7'h01;
            end else begin
                nsamp_next  = nsamp_reg + 1'b1;
            end
            acc_next = acc_sum;
            if (nsamp_next == ratio) begin // [R8]
                // Sum shifted by half log2 ratio [R22] [R15]
                avg_next     = RES_W'(acc_sum >> shift);
                avg_vld_next = 1'b1;
                nsamp_next   = 7'h00; // [R23]
                acc_next     = '0;
            end
        end
    end

    // Offset, gain and code format [R17] [R16]
    always_comb begin
        topbit   = RES_W'(19'h08000 << cfg_reg.oversample_ratio);
        // Offset in raw-code units scaled to the result width [R17]
        offs_val = $signed({1'b0, 1'b0, avg_reg}) +
                   ($signed({{(RES_W-RAW_W+2){cfg_reg.offset[RAW_W-1]}}, cfg_reg.offset})
                    <<< cfg_reg.oversample_ratio);
        if (offs_val < 0) begin
            offs_val = '0;
        end
        // Gain 0x8000 is unity [R17]
        prod     = (offs_val * $signed({1'b0, cfg_reg.gain})) >>> (RAW_W - 1);
        res_next.code = (prod > $signed({3'h0, topbit, 1'b0}) - 1) ?
                        RES_W'({topbit, 1'b0} - 1'b1) : RES_W'(prod);
        // Pseudobipolar flips the top result bit [R16] [R18] [R19] [R20] [R21]
        if (cfg_reg.bipolar) begin
            res_next.code = res_next.code ^ topbit;
        end
        res_next.channel = acc_ch_reg;
        res_next.oversample_ratio     = cfg_reg.oversample_ratio;
        res_vld_next     = avg_vld_reg;
    end

    // Result path registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            acc_ch_reg  <= '0;
            cfg_reg     <= '{oversample_ratio: OSR_1, bipolar: 1'b0, offset: '0, gain: GAIN_UNITY};
            acc_reg     <= '0;
            nsamp_reg   <= '0;
            avg_vld_reg <= 1'b0;
            avg_reg     <= RES_RESET;
            res_reg     <= '0;
            res_vld_reg <= 1'b0;
        end else begin
            acc_ch_reg  <= acc_ch_next;
            cfg_reg     <= cfg_next;
            acc_reg     <= acc_next;
            nsamp_reg   <= nsamp_next;
            avg_vld_reg <= avg_vld_next;
            avg_reg     <= avg_next;
            res_reg     <= res_next;
            res_vld_reg <= res_vld_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer toward readout
    sarcs_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in       (REF_CLK_IN),
        .rst_b_in     (RST_B_IN),
        .wr_data_in   (res_reg),
        .wr_valid_in  (res_vld_reg),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (RESULT_OUT),
        .rd_valid_out (RESULT_VALID_OUT),
        .rd_ready_in  (RESULT_READY_IN)
    );

    // Registered core controls
    assign ARRAY_GROUND_SWITCH_POS_OUT = gnd_sw_reg;
    assign ARRAY_GROUND_SWITCH_NEG_OUT = gnd_sw_reg;
    assign MUX_SWITCH_POS_OUT          = mux_sw_reg;
    assign MUX_SWITCH_NEG_OUT          = mux_sw_reg;
    assign DAC_TRIAL_OUT               = dac_reg;
    assign MUX_CHANNEL_OUT             = ch_reg;
    assign BUSY_OUT                    = busy_reg;
endmodule

// ==== testbench/sarcs_far_model.sv ====
// Host and analog core stand-in: convert-start pulses and comparator decisions
`timescale 1ns/1ps
module sarcs_far_model (
    // Bench controls
    input  wire logic        fire_in,
    input  wire logic [15:0] target_in,
    // Device side
    input  wire logic [15:0] trial_in,
    output logic             convert_start_out,
    output logic             comparator_out
);
    initial convert_start_out = 1'b0;
    // One link period per request, off the device clock phase
    always @(posedge fire_in) begin
        #3 convert_start_out = 1'b1;
        #100 convert_start_out = 1'b0;
    end
    // Ideal comparator: held input at or above the code under trial
    assign comparator_out = (target_in >= trial_in);
endmodule

// ==== testbench/sarcs_top_monitor.sv ====
// Checker of switch, busy, channel and result timing of the conversion sequencer
`timescale 1ns/1ps
module sarcs_top_monitor
    import sarcs_pkg::*;
(
    // Clock, reset and controls
    input  wire logic             REF_CLK_IN,
    input  wire logic             RST_B_IN,
    input  wire logic             CONV_MODE_IN,
    input  wire logic             BUSY_EN_IN,
    input  wire logic             HIZ_EN_IN,
    input  wire sarcs_seq_type    SEQ_MODE_IN,
    input  wire logic             CMD_VALID_IN,
    input  wire logic             RESULT_READY_IN,
    // Observed outputs
    input  wire logic             ARRAY_GROUND_SWITCH_POS_OUT,
    input  wire logic             ARRAY_GROUND_SWITCH_NEG_OUT,
    input  wire logic             MUX_SWITCH_POS_OUT,
    input  wire logic             MUX_SWITCH_NEG_OUT,
    input  wire logic [RAW_W-1:0] DAC_TRIAL_OUT,
    input  wire logic [CH_W-1:0]  MUX_CHANNEL_OUT,
    input  wire logic             BUSY_OUT,
    input  wire sarcs_result_type RESULT_OUT,
    input  wire logic             RESULT_VALID_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    wire logic gnd = ARRAY_GROUND_SWITCH_POS_OUT;
    ////////////////////////////////////////////////////////////
    // Conversion start and trial sequence
    open_first_a: assert property (
        $fell(gnd) |-> !ARRAY_GROUND_SWITCH_NEG_OUT && !MUX_SWITCH_POS_OUT && !MUX_SWITCH_NEG_OUT)
        else $error("switches not open at conversion start");
    msb_first_a: assert property (
        $fell(gnd) |-> DAC_TRIAL_OUT == 16'h8000) else $error("first trial not msb");
    trial_span_a: assert property (
        $fell(gnd) && SEQ_MODE_IN != SARCS_SEQ_SINGLE_CYCLE |->
        (!gnd)[*8] ##1 (!gnd)[*8] ##[1:2] gnd) else $error("conversion length wrong");
    config_hold_a: assert property (
        !CONV_MODE_IN && gnd |=> gnd) else $error("conversion left config mode");
    // Busy indicator
    busy_start_a: assert property (
        $fell(gnd) && BUSY_EN_IN |-> BUSY_OUT) else $error("busy not raised");
    busy_span_a: assert property (
        $rose(BUSY_OUT) |-> BUSY_OUT[*8] ##1 BUSY_OUT[*8] ##[1:2] !BUSY_OUT)
        else $error("busy length wrong");
    busy_phase_a: assert property (
        BUSY_OUT |-> !gnd) else $error("busy during acquisition");
    // Channel, acquisition start and result hold
    mux_move_a: assert property (
        $changed(MUX_CHANNEL_OUT) |-> gnd && !$past(gnd)) else $error("channel moved midway");
    hiz_delay_a: assert property (
        $rose(gnd) && HIZ_EN_IN |-> !MUX_SWITCH_POS_OUT ##[2:6] MUX_SWITCH_POS_OUT)
        else $error("high-z closing time wrong");
    hiz_off_a: assert property (
        $rose(gnd) && !HIZ_EN_IN |-> ##[0:1] MUX_SWITCH_POS_OUT) else $error("mux not closed");
    cmd_gate_a: assert property (
        $rose(gnd) && SEQ_MODE_IN == SARCS_SEQ_SINGLE_CYCLE |->
        $past(CMD_VALID_IN) || $past(CMD_VALID_IN, 2) || $past(CMD_VALID_IN, 3))
        else $error("acquisition before command");
    result_hold_a: assert property (
        RESULT_VALID_OUT && !RESULT_READY_IN |=> RESULT_VALID_OUT && $stable(RESULT_OUT))
        else $error("result dropped while stalled");
endmodule

// ==== testbench/sarcs_top_tb.sv ====
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end
module sarcs_top_tb
    import sarcs_pkg::*;
;
    logic             clk = 1'b0, rst_b = 1'b0, fire = 1'b0, cmd_valid = 1'b0;
    logic             conv_mode = 1'b1, busy_en = 1'b1, hiz_en = 1'b0;
    logic             ready = 1'b1, stall = 1'b0;
    sarcs_seq_type    seq_mode = SARCS_SEQ_TWO_CYCLE;
    logic [CMD_W-1:0] cmd_ch = 5'h00;
    logic [CH_W-1:0]  seq_ch = 4'h0, cur_ch = 4'h0, mux_ch;
    sarcs_chcfg_type  cfg = '{OSR_1, 1'b0, 16'h0000, GAIN_UNITY};
    logic [15:0]      target = 16'h8000;
    logic             convert_start, comp, gnd, valid, busy;
    logic [RAW_W-1:0] trial;
    sarcs_result_type res, head;
    sarcs_result_type exp_q[$];
    logic [31:0]      seed = 32'hab812b8e;
    int               err_count = 0, n_compared = 0;

    sarcs_top dut_u (
        .REF_CLK_IN(clk), .RST_B_IN(rst_b), .CONVERT_START_IN(convert_start), .CONV_MODE_IN(conv_mode),
        .BUSY_EN_IN(busy_en), .HIZ_EN_IN(hiz_en), .SEQ_MODE_IN(seq_mode),
        .CMD_VALID_IN(cmd_valid), .CMD_CHANNEL_IN(cmd_ch), .SEQ_CHANNEL_IN(seq_ch),
        .CH_CFG_IN(cfg), .COMPARATOR_IN(comp), .ARRAY_GROUND_SWITCH_POS_OUT(gnd),
        .ARRAY_GROUND_SWITCH_NEG_OUT(), .MUX_SWITCH_POS_OUT(), .MUX_SWITCH_NEG_OUT(),
        .DAC_TRIAL_OUT(trial), .MUX_CHANNEL_OUT(mux_ch), .BUSY_OUT(busy), .RESULT_OUT(res),
        .RESULT_VALID_OUT(valid), .RESULT_READY_IN(ready)
    );
    sarcs_far_model far_u (
        .fire_in(fire), .target_in(target), .trial_in(trial),
        .convert_start_out(convert_start), .comparator_out(comp)
    );
    // Clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Random reader stalls
    always @(negedge clk) begin
        seed <= xs(seed);
        ready <= !stall && seed[4];
    end
    // Each result taken is matched against the oldest note
    always @(posedge clk) begin
        if (rst_b && valid && ready) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("unexpected result expected none seen %h", res);
            end else begin
                head = exp_q.pop_front();
                `CHK("result", head, res)
            end
        end
    end
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #(25 * 40000);
        err_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////
    task automatic wait_gnd(input logic lvl, input int lim);
        int w;
        w = 0;
        while (gnd !== lvl && w < lim) begin
            @(negedge clk);
            w++;
        end
    endtask
    // One conversion, with the channel command in single-cycle mode
    task automatic conv();
        repeat (ACQ_CYCLES) @(negedge clk);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        wait_gnd(1'b0, 20);
        `CHK("start", 1'b0, gnd)
        if (seq_mode == SARCS_SEQ_SINGLE_CYCLE) begin
            repeat (30) @(negedge clk);
            `CHK("cmd wait", 1'b0, gnd)
            cmd_ch = {1'b0, seq_ch};
            cmd_valid = 1'b1;
            @(negedge clk);
            cmd_valid = 1'b0;
        end
        wait_gnd(1'b1, 40);
        `CHK("acquire", 1'b1, gnd)
        `CHK("channel", seq_ch, mux_ch)
        repeat (6) @(negedge clk);
    endtask
    // One averaged result over a held input; channel moves on the last raw code
    task automatic group(input logic [15:0] t, input logic [1:0] o, input logic bip,
                         input logic [15:0] off, input logic [3:0] nxt, input logic keep);
        logic [18:0] e;
        logic [18:0] top;
        int n;
        top = (19'h10000 << o) - 19'h00001;
        e = (19'(t) + 19'(off)) << o;
        if (e > top) e = top;
        if (bip) e = e ^ (19'h08000 << o);
        n = 1 << (2 * o);
        cfg = '{oversample_ratio: o, bipolar: bip, offset: off, gain: GAIN_UNITY};
        target = t;
        if (keep) exp_q.push_back('{channel: cur_ch, oversample_ratio: o, code: e});
        for (int i = 0; i < n; i++) begin
            seq_ch = (i == n - 1) ? nxt : cur_ch;
            conv();
        end
        cur_ch = nxt;
    endtask
    // Main sequence
    initial begin
        int w;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        for (int o = 0; o < 4; o++) begin
            for (int k = 0; k < ((o == 0) ? 8 : 2); k++) begin
                busy_en = seed[7];
                hiz_en = seed[9];
                seq_mode = k[1] ? SARCS_SEQ_STANDARD : SARCS_SEQ_ADVANCED;
                group(k < 2 ? 16'h8000 : k < 4 ? 16'hffff : k < 6 ? 16'h0000 : seed[15:0],
                      o[1:0], k[0], 16'h0000, seed[3:0], 1'b1);
            end
        end
        seq_mode = SARCS_SEQ_TWO_CYCLE;
        group(16'h1000, 2'h0, 1'b0, 16'h0010, 4'h5, 1'b1);
        group(16'hfffe, 2'h0, 1'b0, 16'h0005, 4'h5, 1'b1);
        // Convert edge in configuration mode is ignored
        conv_mode = 1'b0;
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        repeat (30) @(negedge clk);
        `CHK("config acquire", 1'b1, gnd)
        `CHK("config busy", 1'b0, busy)
        conv_mode = 1'b1;
        seq_mode = SARCS_SEQ_SINGLE_CYCLE;
        group(16'h2345, 2'h0, 1'b1, 16'h0000, 4'hb, 1'b1);
        seq_mode = SARCS_SEQ_TWO_CYCLE;
        // Fill the buffer past its depth while the reader stalls, starting empty
        while (exp_q.size() != 0) @(negedge clk);
        stall = 1'b1;
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            group(seed[15:0], 2'h0, 1'b0, 16'h0000, cur_ch, i < FIFO_DEPTH);
        end
        `CHK("held", 1'b1, valid)
        stall = 1'b0;
        w = 0;
        while ((exp_q.size() != 0 || valid !== 1'b0) && w < 400) begin
            @(negedge clk);
            w++;
        end
        `CHK("drained", 1'b0, valid)
        `CHK("backlog", 0, exp_q.size())
        close_out();
    end
endmodule

bind sarcs_top sarcs_top_monitor mon_u (
    .REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .CONV_MODE_IN(CONV_MODE_IN),
    .BUSY_EN_IN(BUSY_EN_IN), .HIZ_EN_IN(HIZ_EN_IN), .SEQ_MODE_IN(SEQ_MODE_IN),
    .CMD_VALID_IN(CMD_VALID_IN), .RESULT_READY_IN(RESULT_READY_IN),
    .ARRAY_GROUND_SWITCH_POS_OUT(ARRAY_GROUND_SWITCH_POS_OUT),
    .ARRAY_GROUND_SWITCH_NEG_OUT(ARRAY_GROUND_SWITCH_NEG_OUT),
    .MUX_SWITCH_POS_OUT(MUX_SWITCH_POS_OUT), .MUX_SWITCH_NEG_OUT(MUX_SWITCH_NEG_OUT),
    .DAC_TRIAL_OUT(DAC_TRIAL_OUT), .MUX_CHANNEL_OUT(MUX_CHANNEL_OUT), .BUSY_OUT(BUSY_OUT),
    .RESULT_OUT(RESULT_OUT), .RESULT_VALID_OUT(RESULT_VALID_OUT)
);
